// ---- hdl/tbc_pkg.sv ----
// constants of the type-b timer control block
package tbc_pkg;
	// ************************************************************
	// register indices (byte address = 4 * index)
	// ************************************************************
	localparam logic [3:0] IDX_CTRL_A = 4'h0;
	localparam logic [3:0] IDX_CTRL_B = 4'h1;
	localparam logic [3:0] IDX_EVENT = 4'h4;
	localparam logic [3:0] IDX_FLAGS = 4'h6;
	localparam logic [3:0] IDX_STATUS = 4'h7;
	localparam logic [3:0] IDX_COUNT = 4'hA;
	localparam logic [3:0] IDX_CAPTURE_COMPARE_VALUE = 4'hC;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_A_MASK = 8'h7F;
	localparam logic [7:0] CTRL_B_MASK = 8'h77;
	localparam logic [7:0] EVENT_MASK = 8'h51;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int A_ENABLE = 0;
	localparam int A_CLK_LO = 1;
	localparam int A_CLK_HI = 3;
	localparam int A_RESTART = 4;
	localparam int A_CHAIN = 5;
	localparam int A_STANDBY = 6;
	localparam int B_MODE_LO = 0;
	localparam int B_MODE_HI = 2;
	localparam int B_OUT_EN = 4;
	localparam int B_INIT = 5;
	localparam int B_IMMEDIATE = 6;
	localparam int E_CAPTURE_ON_EVENT_EN = 0;
	localparam int E_EDGE = 4;
	localparam int E_FILTER = 6;
	localparam int F_CAPTURE_ON_EVENT = 0;
	localparam int F_WRAP = 1;
	localparam int S_RUN = 0;
	// ************************************************************
	// clock source and mode codes
	// ************************************************************
	localparam logic [2:0] CLK_UNDIVIDED = 3'h0;
	localparam logic [2:0] CLK_HALF = 3'h1;
	localparam logic [2:0] CLK_TYPE_A_ZERO = 3'h2;
	localparam logic [2:0] CLK_TYPE_A_ONE = 3'h3;
	localparam logic [2:0] CLK_EVENT = 3'h7;
	localparam logic [2:0] MODE_PERIODIC = 3'h0;
	localparam logic [2:0] MODE_TIMEOUT = 3'h1;
	localparam logic [2:0] MODE_CAPTURE = 3'h2;
	localparam logic [2:0] MODE_FREQ = 3'h3;
	localparam logic [2:0] MODE_WIDTH = 3'h4;
	localparam logic [2:0] MODE_FREQ_WIDTH = 3'h5;
	localparam logic [2:0] MODE_SINGLE = 3'h6;
	localparam logic [2:0] MODE_BYTE_PWM = 3'h7;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	// noise filter needs three equal samples after the first; this is the all-high history
	localparam logic [2:0] FILTER_ALL = 3'h7;
	localparam logic [2:0] FILTER_NONE = 3'h0;
	typedef enum logic [1:0] {TBC_FP_IDLE, TBC_FP_COUNT, TBC_FP_HOLD} tbc_fp_t;
endpackage

// ---- hdl/tbc_timer.sv ----
// control, event actions and register slave of the type-b timer
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
// Overview of operation
// - standby run bit keeps the timer working in standby sleep
// - chain bit on the upper timer joins two timers into 32 bits
// - with chain set the capture event is delayed one clock
// - restart bit restarts counter on the associated type-a restart
// - clock select: undivided, half, type-a zero/one, event edge
// - timer works only while enable bit is one
// - single shot output rises after sync start, or at once if immediate
// - initial level sets output start level, not in byte pwm or single
// - output enable lets the waveform drive the pin
// - mode field: periodic, timeout, capture, freq, width, both, single, pwm
// - filter bit enables noise cancellation on capture input
// - timeout start/stop per edge select; single shot start edges
// - periodic and byte pwm modes ignore capture events
// - capture mode captures on chosen edge; freq mode also restarts
// - width mode: one edge restarts, the other captures
// - freq plus width: restart, capture, then stop and flag
// - capture events act only while capture input enable is one
// - capture flag clears on write one or capture read in capture modes
// - byte pwm: low byte period, high byte duty
// - wrap flag sets when counter wraps from max to zero
module tbc_timer (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic standby_sleep,
	input wire logic capture_event,
	input wire logic count_event,
	input wire logic type_a_timer_zero_tick,
	input wire logic type_a_timer_one_tick,
	input wire logic type_a_timer_zero_restart,
	input wire logic type_a_timer_one_restart,
	output logic wave_out,
	output logic wave_oe_n
);
	logic [7:0] ctrl_a_r;
	logic [7:0] ctrl_b_r;
	logic [7:0] event_r;
	logic [15:0] count_r;
	logic [15:0] capture_compare_value_r;
	logic run_r;
	logic capture_on_event_flag_r;
	logic wrap_flag_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic wave_r;
	logic oe_n_r;
	logic half_r;
	logic count_prev_r;
	logic [2:0] hist_r;
	logic filt_r;
	logic dly_r;
	logic prev_r;
	tbc_pkg::tbc_fp_t fp_r;
	logic [2:0] mode;
	logic [2:0] clk_sel;
	logic active;
	logic tick;
	logic step;
	logic sync_restart;
	logic lvl_a;
	logic lvl_b;
	logic pos;
	logic neg;
	logic ev_first;
	logic ev_other;
	logic trig;
	logic take;
	logic wr;
	logic [3:0] idx;

	// modes that load the capture register from events
	function automatic logic is_capture(input logic [2:0] m);
		is_capture = (m >= tbc_pkg::MODE_CAPTURE) && (m <= tbc_pkg::MODE_FREQ_WIDTH);
	endfunction

	// modes that force their own output level
	function automatic logic own_level(input logic [2:0] m);
		own_level = (m == tbc_pkg::MODE_SINGLE) || (m == tbc_pkg::MODE_BYTE_PWM);
	endfunction

	// ************************************************************
	// avalon slave
	// ************************************************************
	assign take = (avs_read || avs_write) && !wait_r;
	assign wr = avs_write && !wait_r;
	assign idx = avs_address[5:2];

	// one wait cycle per access; read data ready when wait drops
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wait_r <= 1'b1;
		end else begin
			wait_r <= !((avs_read || avs_write) && wait_r);
		end
	end

	// read mux, unmapped words read zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata_r <= 32'h00000000;
		end else if (avs_read && wait_r) begin
			case (idx)
				tbc_pkg::IDX_CTRL_A: rdata_r <= {24'h000000, ctrl_a_r};
				tbc_pkg::IDX_CTRL_B: rdata_r <= {24'h000000, ctrl_b_r};
				tbc_pkg::IDX_EVENT: rdata_r <= {24'h000000, event_r};
				tbc_pkg::IDX_FLAGS: rdata_r <= {30'h0, wrap_flag_r, capture_on_event_flag_r};
				tbc_pkg::IDX_STATUS: rdata_r <= {31'h0, run_r};
				tbc_pkg::IDX_COUNT: rdata_r <= {16'h0000, count_r};
				tbc_pkg::IDX_CAPTURE_COMPARE_VALUE: rdata_r <= {16'h0000, capture_compare_value_r};
				default: rdata_r <= 32'h00000000;
			endcase
		end
	end

	// control registers, reserved bits masked to zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_a_r <= tbc_pkg::CTRL_RESET;
			ctrl_b_r <= tbc_pkg::CTRL_RESET;
			event_r <= tbc_pkg::CTRL_RESET;
		end else if (wr && avs_byteenable[0]) begin
			if (idx == tbc_pkg::IDX_CTRL_A)
				ctrl_a_r <= avs_writedata[7:0] & tbc_pkg::CTRL_A_MASK;
			if (idx == tbc_pkg::IDX_CTRL_B)
				ctrl_b_r <= avs_writedata[7:0] & tbc_pkg::CTRL_B_MASK;
			if (idx == tbc_pkg::IDX_EVENT)
				event_r <= avs_writedata[7:0] & tbc_pkg::EVENT_MASK;
		end
	end

	// ************************************************************
	// clocking and enable
	// ************************************************************
	assign mode = ctrl_b_r[tbc_pkg::B_MODE_HI:tbc_pkg::B_MODE_LO];
	assign clk_sel = ctrl_a_r[tbc_pkg::A_CLK_HI:tbc_pkg::A_CLK_LO];
	assign active = ctrl_a_r[tbc_pkg::A_ENABLE]
		&& (!standby_sleep || ctrl_a_r[tbc_pkg::A_STANDBY]);

	// half-rate prescaler and count event edge history
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			half_r <= 1'b0;
			count_prev_r <= 1'b0;
		end else begin
			half_r <= active && !half_r;
			count_prev_r <= count_event;
		end
	end

	// count tick; reserved codes give none so the count freezes
	always_comb begin
		case (clk_sel)
			tbc_pkg::CLK_UNDIVIDED: tick = 1'b1;
			tbc_pkg::CLK_HALF: tick = half_r;
			tbc_pkg::CLK_TYPE_A_ZERO: tick = type_a_timer_zero_tick;
			tbc_pkg::CLK_TYPE_A_ONE: tick = type_a_timer_one_tick;
			tbc_pkg::CLK_EVENT: tick = count_event && !count_prev_r;
			default: tick = 1'b0;
		endcase
	end

	// restart follows the clock-source type-a timer, else timer zero
	assign sync_restart = active && ctrl_a_r[tbc_pkg::A_RESTART]
		&& ((clk_sel == tbc_pkg::CLK_TYPE_A_ONE) ? type_a_timer_one_restart
		: type_a_timer_zero_restart);
	assign step = active && run_r && tick;

	// ************************************************************
	// capture event path
	// ************************************************************
	// filter: level only moves after four equal samples
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hist_r <= tbc_pkg::FILTER_NONE;
			filt_r <= 1'b0;
			dly_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			hist_r <= {hist_r[1:0], capture_event};
			if ((capture_event && hist_r == tbc_pkg::FILTER_ALL)
				|| (!capture_event && hist_r == tbc_pkg::FILTER_NONE))
				filt_r <= capture_event;
			dly_r <= lvl_a;
			prev_r <= lvl_b;
		end
	end

	assign lvl_a = event_r[tbc_pkg::E_FILTER] ? filt_r : capture_event;
	// lower timer's carry arrives a cycle late through the event network
	assign lvl_b = ctrl_a_r[tbc_pkg::A_CHAIN] ? dly_r : lvl_a;
	assign pos = lvl_b && !prev_r;
	assign neg = !lvl_b && prev_r;
	assign ev_first = active && event_r[tbc_pkg::E_CAPTURE_ON_EVENT_EN]
		&& (event_r[tbc_pkg::E_EDGE] ? neg : pos);
	assign ev_other = active && event_r[tbc_pkg::E_CAPTURE_ON_EVENT_EN]
		&& (event_r[tbc_pkg::E_EDGE] ? pos : neg);
	// edge select one in single shot starts on either edge
	assign trig = ev_first || (event_r[tbc_pkg::E_EDGE] && ev_other);

	// ************************************************************
	// counter, capture and flags
	// ************************************************************
	// later assignments win: flag clears, then count, events, disable, restart, bus writes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count_r <= tbc_pkg::COUNT_ZERO;
			capture_compare_value_r <= tbc_pkg::COUNT_ZERO;
			run_r <= 1'b0;
			capture_on_event_flag_r <= 1'b0;
			wrap_flag_r <= 1'b0;
			fp_r <= tbc_pkg::TBC_FP_IDLE;
		end else begin
			// flag clears first so a same-cycle set still lands
			if (wr && avs_byteenable[0] && idx == tbc_pkg::IDX_FLAGS) begin
				if (avs_writedata[tbc_pkg::F_CAPTURE_ON_EVENT])
					capture_on_event_flag_r <= 1'b0;
				if (avs_writedata[tbc_pkg::F_WRAP])
					wrap_flag_r <= 1'b0;
			end
			if (take && avs_read && idx == tbc_pkg::IDX_CAPTURE_COMPARE_VALUE && is_capture(mode))
				capture_on_event_flag_r <= 1'b0;
			if (step) begin
				count_r <= count_r + 16'h0001;
				if (count_r == tbc_pkg::COUNT_MAX)
					wrap_flag_r <= 1'b1;
			end
			case (mode)
				tbc_pkg::MODE_PERIODIC: begin
					run_r <= active;
					if (step && count_r == capture_compare_value_r) begin
						count_r <= tbc_pkg::COUNT_ZERO;
						capture_on_event_flag_r <= 1'b1;
					end
				end
				tbc_pkg::MODE_TIMEOUT: begin
					if (ev_first)
						run_r <= 1'b1;
					if (ev_other)
						run_r <= 1'b0;
					if (step && count_r == capture_compare_value_r) begin
						count_r <= tbc_pkg::COUNT_ZERO;
						capture_on_event_flag_r <= 1'b1;
					end
				end
				tbc_pkg::MODE_CAPTURE: begin
					run_r <= active;
					if (ev_first) begin
						capture_compare_value_r <= count_r;
						capture_on_event_flag_r <= 1'b1;
					end
				end
				tbc_pkg::MODE_FREQ: begin
					run_r <= active;
					if (ev_first) begin
						capture_compare_value_r <= count_r;
						count_r <= tbc_pkg::COUNT_ZERO;
						capture_on_event_flag_r <= 1'b1;
					end
				end
				tbc_pkg::MODE_WIDTH: begin
					run_r <= active;
					if (ev_first)
						count_r <= tbc_pkg::COUNT_ZERO;
					if (ev_other) begin
						capture_compare_value_r <= count_r;
						capture_on_event_flag_r <= 1'b1;
					end
				end
				tbc_pkg::MODE_FREQ_WIDTH: begin
					case (fp_r)
						tbc_pkg::TBC_FP_IDLE: begin
							if (ev_first) begin
								count_r <= tbc_pkg::COUNT_ZERO;
								run_r <= 1'b1;
								fp_r <= tbc_pkg::TBC_FP_COUNT;
							end
						end
						tbc_pkg::TBC_FP_COUNT: begin
							if (ev_other) begin
								capture_compare_value_r <= count_r;
								fp_r <= tbc_pkg::TBC_FP_HOLD;
							end
						end
						tbc_pkg::TBC_FP_HOLD: begin
							if (ev_first) begin
								run_r <= 1'b0;
								capture_on_event_flag_r <= 1'b1;
								fp_r <= tbc_pkg::TBC_FP_IDLE;
							end
						end
						default: fp_r <= tbc_pkg::TBC_FP_IDLE;
					endcase
				end
				tbc_pkg::MODE_SINGLE: begin
					if (trig && !run_r) begin
						run_r <= 1'b1;
						count_r <= tbc_pkg::COUNT_ZERO;
					end else if (step && count_r == capture_compare_value_r) begin
						run_r <= 1'b0;
						count_r <= tbc_pkg::COUNT_ZERO;
						capture_on_event_flag_r <= 1'b1;
					end
				end
				tbc_pkg::MODE_BYTE_PWM: begin
					run_r <= active;
					if (step && count_r[7:0] == capture_compare_value_r[7:0])
						count_r <= tbc_pkg::COUNT_ZERO;
					if (step && count_r[7:0] == capture_compare_value_r[15:8])
						capture_on_event_flag_r <= 1'b1;
				end
				default: run_r <= 1'b0;
			endcase
			if (!active) begin
				run_r <= 1'b0;
				fp_r <= tbc_pkg::TBC_FP_IDLE;
			end
			if (sync_restart)
				count_r <= tbc_pkg::COUNT_ZERO;
			// count and compare writes take priority over hardware updates
			if (wr && idx == tbc_pkg::IDX_COUNT) begin
				if (avs_byteenable[0])
					count_r[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1])
					count_r[15:8] <= avs_writedata[15:8];
			end
			if (wr && idx == tbc_pkg::IDX_CAPTURE_COMPARE_VALUE) begin
				if (avs_byteenable[0])
					capture_compare_value_r[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1])
					capture_compare_value_r[15:8] <= avs_writedata[15:8];
			end
		end
	end

	// ************************************************************
	// waveform output
	// ************************************************************
	// sync start shows one cycle after run; immediate mode shows at the edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wave_r <= 1'b0;
			oe_n_r <= 1'b1;
		end else begin
			oe_n_r <= !ctrl_b_r[tbc_pkg::B_OUT_EN];
			if (!active) begin
				wave_r <= own_level(mode) ? 1'b0 : ctrl_b_r[tbc_pkg::B_INIT];
			end else if (mode == tbc_pkg::MODE_SINGLE) begin
				wave_r <= run_r || (ctrl_b_r[tbc_pkg::B_IMMEDIATE] && trig);
			end else if (mode == tbc_pkg::MODE_BYTE_PWM) begin
				wave_r <= count_r[7:0] < capture_compare_value_r[15:8];
			end
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign wave_out = wave_r;
	assign wave_oe_n = oe_n_r;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// run one cycle after the edge with the pin still low, pin high the cycle after
	sequence s_sync_start;
		##1 (run_r && !wave_r) ##1 wave_r;
	endsequence

	property p_disabled_halts;
		!ctrl_a_r[tbc_pkg::A_ENABLE] |=> !run_r;
	endproperty
	a_disabled_halts: assert property (p_disabled_halts) else $error("run while disabled");

	property p_standby_freeze;
		standby_sleep && !ctrl_a_r[tbc_pkg::A_STANDBY] && !wr |=> $stable(count_r);
	endproperty
	a_standby_freeze: assert property (p_standby_freeze) else $error("count in standby");

	property p_chain_delay;
		ctrl_a_r[tbc_pkg::A_CHAIN] && $stable(ctrl_a_r) |-> lvl_b == $past(lvl_a);
	endproperty
	a_chain_delay: assert property (p_chain_delay) else $error("chain delay wrong");

	property p_reserved_clock;
		clk_sel > tbc_pkg::CLK_TYPE_A_ONE && clk_sel < tbc_pkg::CLK_EVENT |-> !tick;
	endproperty
	a_reserved_clock: assert property (p_reserved_clock) else $error("reserved code ticks");

	property p_single_sync;
		mode == tbc_pkg::MODE_SINGLE && !ctrl_b_r[tbc_pkg::B_IMMEDIATE] && trig && !run_r
			&& !wr && $stable(ctrl_b_r) |-> s_sync_start;
	endproperty
	a_single_sync: assert property (p_single_sync) else $error("single shot sync late");

	property p_single_now;
		mode == tbc_pkg::MODE_SINGLE && ctrl_b_r[tbc_pkg::B_IMMEDIATE] && trig |=> wave_r;
	endproperty
	a_single_now: assert property (p_single_now) else $error("single shot not immediate");

	property p_output_enable;
		ctrl_b_r[tbc_pkg::B_OUT_EN] |=> !wave_oe_n;
	endproperty
	a_output_enable: assert property (p_output_enable) else $error("pin not driven");

	property p_capture_off;
		!event_r[tbc_pkg::E_CAPTURE_ON_EVENT_EN] && !wr |=> $stable(capture_compare_value_r);
	endproperty
	a_capture_off: assert property (p_capture_off) else $error("capture with input off");

	property p_freq_restart;
		mode == tbc_pkg::MODE_FREQ && ev_first && !sync_restart && !wr
			|=> count_r == tbc_pkg::COUNT_ZERO && capture_on_event_flag_r && capture_compare_value_r == $past(count_r);
	endproperty
	a_freq_restart: assert property (p_freq_restart) else $error("freq capture wrong");

	property p_init_level;
		!active && !own_level(mode) |=> wave_r == $past(ctrl_b_r[tbc_pkg::B_INIT]);
	endproperty
	a_init_level: assert property (p_init_level) else $error("initial level wrong");
endmodule // tbc_timer

// ---- test/tbc_far_model.sv ----
// far side model: event network and type-a timers
`timescale 1ns/1ns
module tbc_far_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cap_lvl,
	input wire logic rq0,
	input wire logic rq1,
	output logic capture_event,
	output logic count_event,
	output logic type_a_timer_zero_tick,
	output logic type_a_timer_one_tick,
	output logic type_a_timer_zero_restart,
	output logic type_a_timer_one_restart
);
	logic [1:0] phase_r;
	// free running prescaler of the type-a timers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase_r <= 2'h0;
		end else begin
			phase_r <= phase_r + 2'h1;
		end
	end
	// ticks every 2 and every 4 cycles, count edge every 4
	assign type_a_timer_zero_tick = phase_r[0];
	assign type_a_timer_one_tick = (phase_r == 2'h3);
	assign count_event = phase_r[1];
	// routed events are registered, so each level lasts whole clocks
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			capture_event <= 1'h0;
			type_a_timer_zero_restart <= 1'h0;
			type_a_timer_one_restart <= 1'h0;
		end else begin
			capture_event <= cap_lvl;
			type_a_timer_zero_restart <= rq0;
			type_a_timer_one_restart <= rq1;
		end
	end
endmodule // tbc_far_model

// ---- test/tb_top.sv ----
// self-checking bench of the type-b timer control block
`timescale 1ns/1ns
module tb_top;
	localparam logic [3:0] IA = tbc_pkg::IDX_CTRL_A;
	localparam logic [3:0] IB = tbc_pkg::IDX_CTRL_B;
	localparam logic [3:0] IE = tbc_pkg::IDX_EVENT;
	localparam logic [3:0] IF = tbc_pkg::IDX_FLAGS;
	localparam logic [3:0] IS = tbc_pkg::IDX_STATUS;
	localparam logic [3:0] IK = tbc_pkg::IDX_COUNT;
	localparam logic [3:0] IC = tbc_pkg::IDX_CAPTURE_COMPARE_VALUE;
	logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, wave_out, wave_oe_n;
	logic standby_sleep, cap_lvl, rq0, rq1, cap_ev, cnt_ev, t0, t1, r0, r1;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, v, w;
	logic [3:0] ix [3];
	logic [7:0] mk [3];
	int errors, total_checks, cyc, n1, n2;
	// ************************************************************
	// instances and clock
	// ************************************************************
	tbc_timer dut (
		.ref_clk(ref_clk),
		.rst(rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_byteenable(4'hF),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.standby_sleep(standby_sleep),
		.capture_event(cap_ev),
		.count_event(cnt_ev),
		.type_a_timer_zero_tick(t0),
		.type_a_timer_one_tick(t1),
		.type_a_timer_zero_restart(r0),
		.type_a_timer_one_restart(r1),
		.wave_out(wave_out),
		.wave_oe_n(wave_oe_n)
	);
	tbc_far_model far (
		.ref_clk(ref_clk),
		.rst(rst),
		.cap_lvl(cap_lvl),
		.rq0(rq0),
		.rq1(rq1),
		.capture_event(cap_ev),
		.count_event(cnt_ev),
		.type_a_timer_zero_tick(t0),
		.type_a_timer_one_tick(t1),
		.type_a_timer_zero_restart(r0),
		.type_a_timer_one_restart(r1)
	);
	initial begin
		ref_clk = 1'h0;
		forever #50 ref_clk = ~ref_clk;
	end
	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		if (errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// one access held until waitrequest low, then one idle edge
	task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d,
			output logic [31:0] q);
		avs_address <= {a, 2'h0};
		avs_writedata <= d;
		avs_write <= we;
		avs_read <= ~we;
		// no local limit: only the hang guard may end this wait
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'h0);
		q = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'h1, a, d, w);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] q);
		bus(1'h0, a, 32'h0, q);
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	// count advance over a window of 20 cycles between two reads
	task automatic rate(input logic [7:0] ca, input logic slp, input logic [15:0] exp);
		logic [31:0] a;
		logic [31:0] b;
		wr(IA, {24'h0, ca});
		standby_sleep <= slp;
		rd(IK, a);
		repeat (17) @(posedge ref_clk);
		rd(IK, b);
		chk({16'h0, b[15:0] - a[15:0]}, {16'h0, exp});
		standby_sleep <= 1'h0;
	endtask
	// bit 0 of a register after the rising and after the falling edge
	task automatic cap(input logic [7:0] cb, input logic [7:0] ev, input logic [3:0] a,
			input logic er, input logic ef);
		logic [31:0] q;
		wr(IB, {24'h0, cb});
		wr(IE, {24'h0, ev});
		wr(IF, 32'h3);
		wr(IK, 32'h0);
		cap_lvl <= 1'h1;
		repeat (8) @(posedge ref_clk);
		rd(a, q);
		chk({31'h0, q[0]}, {31'h0, er});
		cap_lvl <= 1'h0;
		repeat (8) @(posedge ref_clk);
		rd(a, q);
		chk({31'h0, q[0]}, {31'h0, ef});
	endtask
	// a pulse of len cycles in capture mode; two fall short of the filter's run
	task automatic glt(input logic [7:0] ev, input int len, input logic exp);
		logic [31:0] q;
		wr(IB, 32'h2);
		wr(IE, {24'h0, ev});
		wr(IF, 32'h3);
		cap_lvl <= 1'h1;
		repeat (len) @(posedge ref_clk);
		cap_lvl <= 1'h0;
		repeat (12) @(posedge ref_clk);
		rd(IF, q);
		chk({31'h0, q[0]}, {31'h0, exp});
	endtask
	// cycles from the event level change to a high output, 20 if none;
	// halted while set up so no run is left over from the previous mode
	task automatic shot(input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] ev,
			input logic lvl, output int n);
		wr(IA, 32'h0);
		wr(IB, {24'h0, cb});
		wr(IE, {24'h0, ev});
		wr(IA, {24'h0, ca});
		cap_lvl <= lvl;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wave_out !== 1'h1 && n < 20);
		repeat (40) @(posedge ref_clk);
	endtask
	// high cycles of the byte pwm output over two periods of ten
	task automatic pwm(output int k);
		wr(IC, 32'h0409);
		wr(IB, 32'h17);
		wr(IK, 32'h0);
		k = 0;
		repeat (20) begin
			@(posedge ref_clk);
			if (wave_out === 1'h1)
				k++;
		end
	endtask
	task automatic pulse(input logic one);
		rq0 <= ~one;
		rq1 <= one;
		@(posedge ref_clk);
		rq0 <= 1'h0;
		rq1 <= 1'h0;
		repeat (3) @(posedge ref_clk);
	endtask
	// hang guard, far above the thousand-odd cycles the run needs
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			stop_test();
		end
	end
	initial begin
		{rst, avs_read, avs_write, standby_sleep, cap_lvl, rq0, rq1} = 7'h40;
		avs_address = 6'h0;
		avs_writedata = 32'h0;
		errors = 0;
		total_checks = 0;
		cyc = 0;
		ix = '{IA, IB, IE};
		mk = '{tbc_pkg::CTRL_A_MASK, tbc_pkg::CTRL_B_MASK, tbc_pkg::EVENT_MASK};
		repeat (2) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		chk({31'h0, wave_oe_n}, 32'h1);
		for (int i = 0; i < 3; i++) begin
			rd(ix[i], v);
			chk(v, 32'h0);
			wr(ix[i], 32'hFF);
			rd(ix[i], v);
			chk(v, {24'h0, mk[i]});
			wr(ix[i], 32'h0);
		end
		wr(4'h3, 32'hFF);
		rd(4'h3, v);
		chk(v, 32'h0);
		wr(IC, 32'hFFFF);
		wr(IK, 32'h0);
		rate(8'h01, 1'h0, 16'h14);
		rate(8'h00, 1'h0, 16'h0);
		rate(8'h03, 1'h0, 16'hA);
		rate(8'h05, 1'h0, 16'hA);
		rate(8'h07, 1'h0, 16'h5);
		rate(8'h0F, 1'h0, 16'h5);
		rate(8'h09, 1'h0, 16'h0);
		rate(8'h01, 1'h1, 16'h0);
		rate(8'h41, 1'h1, 16'h14);
		wr(IF, 32'h3);
		wr(IK, 32'hFFF8);
		repeat (20) @(posedge ref_clk);
		rd(IF, v);
		chk(v & 32'h2, 32'h2);
		wr(IA, 32'h11);
		wr(IK, 32'h1000);
		pulse(1'h0);
		rd(IK, v);
		chk({28'h0, v[15:12]}, 32'h0);
		wr(IA, 32'h17);
		wr(IK, 32'h1000);
		pulse(1'h0);
		rd(IK, v);
		chk({28'h0, v[15:12]}, 32'h1);
		pulse(1'h1);
		rd(IK, v);
		chk({28'h0, v[15:12]}, 32'h0);
		// initial level loads while halted; output enable drives wave_oe_n low
		wr(IA, 32'h00);
		wr(IB, 32'h30);
		repeat (3) @(posedge ref_clk);
		chk({31'h0, wave_oe_n}, 32'h0);
		chk({31'h0, wave_out}, 32'h1);
		wr(IB, 32'h10);
		repeat (3) @(posedge ref_clk);
		chk({31'h0, wave_out}, 32'h0);
		wr(IB, 32'h00);
		wr(IA, 32'h01);
		repeat (3) @(posedge ref_clk);
		chk({31'h0, wave_oe_n}, 32'h1);
		cap(8'h02, 8'h01, IF, 1'h1, 1'h1);
		rd(IC, v);
		rd(IF, v);
		chk({31'h0, v[0]}, 32'h0);
		cap(8'h02, 8'h11, IF, 1'h0, 1'h1);
		cap(8'h02, 8'h10, IF, 1'h0, 1'h0);
		wr(IC, 32'hFFFF);
		cap(8'h00, 8'h01, IF, 1'h0, 1'h0);
		cap(8'h03, 8'h01, IF, 1'h1, 1'h1);
		wr(IF, 32'h1);
		rd(IF, v);
		chk({31'h0, v[0]}, 32'h0);
		cap(8'h04, 8'h01, IF, 1'h0, 1'h1);
		cap(8'h04, 8'h11, IF, 1'h1, 1'h1);
		cap(8'h01, 8'h01, IS, 1'h1, 1'h0);
		cap(8'h01, 8'h11, IS, 1'h0, 1'h1);
		cap(8'h05, 8'h01, IF, 1'h0, 1'h0);
		cap_lvl <= 1'h1;
		repeat (8) @(posedge ref_clk);
		rd(IF, v);
		chk({31'h0, v[0]}, 32'h1);
		rd(IS, v);
		chk({31'h0, v[0]}, 32'h0);
		cap_lvl <= 1'h0;
		glt(8'h01, 2, 1'h1);
		glt(8'h41, 2, 1'h0);
		glt(8'h41, 6, 1'h1);
		wr(IC, 32'h10);
		shot(8'h01, 8'h16, 8'h01, 1'h1, n1);
		shot(8'h01, 8'h16, 8'h01, 1'h0, n2);
		chk(32'(n2), 32'h14);
		shot(8'h01, 8'h56, 8'h01, 1'h1, n2);
		chk(32'(n1 - n2), 32'h1);
		shot(8'h01, 8'h16, 8'h11, 1'h0, n2);
		chk(32'(n2), 32'(n1));
		shot(8'h21, 8'h16, 8'h01, 1'h1, n2);
		chk(32'(n2 - n1), 32'h1);
		pwm(n1);
		chk(32'(n1), 32'h8);
		stop_test();
	end
endmodule // tb_top
